// *** asp_defs.svh ***
// Operation
// RULE1: host holds address and data-in hold controls high for transparent operation
// RULE2: both byte strobes stay high for the whole read cycle
// RULE3: address changes only while both byte strobes are high
// RULE4: a write asserts one or both byte strobes with setup and hold
// RULE5: chip select released with or before strobes keeps memory outputs off
// RULE6: chip select asserted with or after strobes keeps outputs off
// RULE7: output enable asserted with or after strobe keeps outputs off
// RULE8: strobe asserted turns memory outputs off; they return afterwards
// RULE9: output enable or chip select released turns memory outputs off
// RULE10: address valid before or with chip select falling
// RULE11: low strobe writes bits 0 to 8, high strobe bits 9 to 17
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_CLK_PS 8000
// address setup to strobe or select, ns
`define ASP_T_SETUP_NS 2
// strobe pulse width, ns
`define ASP_T_WPULSE_NS 13
// read access from select, ns
`define ASP_T_ACCESS_NS 15
// output turn-off after output enable high, ns
`define ASP_T_OFF_NS 9
`define ASP_CYC(ns) ((((ns) * 1000) + `ASP_CLK_PS - 1) / `ASP_CLK_PS)
`define ASP_SETUP_CYC `ASP_CYC(`ASP_T_SETUP_NS)
`define ASP_WPULSE_CYC `ASP_CYC(`ASP_T_WPULSE_NS)
`define ASP_ACCESS_CYC `ASP_CYC(`ASP_T_ACCESS_NS)
`define ASP_OFF_CYC `ASP_CYC(`ASP_T_OFF_NS)
// extra read cycles while read data walks through the pin stages
`define ASP_SYNC_CYC 3
`define ASP_LO_MSB 8
`define ASP_HI_LSB 9
`endif

// *** asp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "asp_defs.svh"
module asp_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire asp_pkg::asp_req_s req,
  // user answer
  output logic rsp_valid,
  output asp_pkg::asp_data_t rsp_data,
  // memory pins
  output asp_pkg::asp_addr_t mem_addr,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic lo_byte_strobe_n,
  output logic hi_byte_strobe_n,
  output logic addr_hold_ctl,
  output logic din_hold_ctl,
  input wire asp_pkg::asp_data_t shared_data_pins_in,
  output asp_pkg::asp_data_t shared_data_pins_out,
  output logic shared_data_pins_oe
);
  import asp_pkg::*;

  // sequencer and its timer
  asp_state_e state_ff;
  asp_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;

  // request held for the whole access
  asp_req_s cur_ff;
  logic take;

  // moments at which a phase ends
  logic setup_end;
  logic strobe_end;
  logic read_end;

  // read data pin stages
  asp_data_t sync1_ff;
  asp_data_t sync2_ff;
  asp_data_t sync3_ff;
  logic pins_settled;

  // answer to the user
  logic rsp_valid_ff;
  asp_data_t rsp_data_ff;

  // memory control pins
  logic cs_n_ff;
  logic oe_n_ff;
  logic [1:0] strobe_n_ff;
  logic doe_ff;
  asp_addr_t addr_ff;

  // a timer that has run out
  function automatic logic cnt_done(input logic [3:0] cnt);
    cnt_done = (cnt == 4'h0);
  endfunction

  // the transparent latches stay open
  assign addr_hold_ctl = 1'b1; // RULE1
  assign din_hold_ctl = 1'b1; // RULE1

  // outputs
  assign req_ready = (state_ff == ASP_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign mem_addr = addr_ff;
  assign chip_sel_n = cs_n_ff;
  assign out_en_n = oe_n_ff;
  assign lo_byte_strobe_n = strobe_n_ff[0];
  assign hi_byte_strobe_n = strobe_n_ff[1];
  assign shared_data_pins_oe = doe_ff;
  assign shared_data_pins_out = cur_ff.wdata;

  // a write with no byte lane is not taken
  assign take = req_valid && req_ready && (!req.write || (req.byte_en != 2'h0)); // RULE4

  // phase ends
  assign setup_end = (state_ff == ASP_SETUP) && cnt_done(cnt_ff);
  assign strobe_end = (state_ff == ASP_STROBE) && cnt_done(cnt_ff);
  assign read_end = (state_ff == ASP_READ) && cnt_done(cnt_ff) && pins_settled;

  // read data counts once the last two stages agree
  assign pins_settled = (sync2_ff == sync3_ff);

  // read data pins through three stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 18'h00000;
      sync2_ff <= 18'h00000;
      sync3_ff <= 18'h00000;
    end else begin
      sync1_ff <= shared_data_pins_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ASP_IDLE: begin
        if (take) begin
          nxt_state = ASP_SETUP;
        end
      end
      ASP_SETUP: begin
        if (setup_end) begin
          if (cur_ff.write) begin
            nxt_state = ASP_STROBE;
          end else begin
            nxt_state = ASP_READ;
          end
        end
      end
      ASP_STROBE: begin
        if (strobe_end) begin
          nxt_state = ASP_HOLD;
        end
      end
      ASP_HOLD: begin
        nxt_state = ASP_IDLE; // RULE3
      end
      ASP_READ: begin
        if (read_end) begin
          nxt_state = ASP_OFF;
        end
      end
      ASP_OFF: begin
        if (cnt_done(cnt_ff)) begin
          nxt_state = ASP_IDLE;
        end
      end
      default: begin
        nxt_state = ASP_IDLE;
      end
    endcase
  end

  // next timer value
  always_comb begin
    if (cnt_done(cnt_ff)) begin
      nxt_cnt = 4'h0;
    end else begin
      nxt_cnt = cnt_ff - 4'h1;
    end
    if (take) begin
      nxt_cnt = 4'(`ASP_SETUP_CYC);
    end else if (setup_end && cur_ff.write) begin
      nxt_cnt = 4'(`ASP_WPULSE_CYC); // RULE4
    end else if (setup_end) begin
      nxt_cnt = 4'(`ASP_ACCESS_CYC + `ASP_SYNC_CYC);
    end else if (read_end) begin
      nxt_cnt = 4'(`ASP_OFF_CYC);
    end
  end

  // state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ASP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // request capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else if (take) begin
      cur_ff <= req;
    end
  end

  // address moves only in idle, with both strobes high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= 16'h0000;
    end else if (take) begin
      addr_ff <= req.addr; // RULE3 RULE10
    end
  end

  // chip select falls after the address has settled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_n_ff <= 1'b1;
    end else if (setup_end) begin
      cs_n_ff <= 1'b0; // RULE10
    end else if ((state_ff == ASP_HOLD) || read_end) begin
      cs_n_ff <= 1'b1; // RULE4
    end
  end

  // output enable only for reads
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_n_ff <= 1'b1;
    end else if (setup_end && !cur_ff.write) begin
      oe_n_ff <= 1'b0; // RULE2 RULE9
    end else if (read_end) begin
      oe_n_ff <= 1'b1;
    end
  end

  // one strobe per byte lane
  generate
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          strobe_n_ff[lane] <= 1'b1;
        end else if (setup_end && cur_ff.write) begin
          strobe_n_ff[lane] <= ~cur_ff.byte_en[lane]; // RULE4 RULE11
        end else if (strobe_end) begin
          strobe_n_ff[lane] <= 1'b1; // RULE3
        end
      end
    end
  endgenerate

  // write data driven from take until select is released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doe_ff <= 1'b0;
    end else if (take) begin
      doe_ff <= req.write;
    end else if (state_ff == ASP_HOLD) begin
      doe_ff <= 1'b0;
    end
  end

  // answer pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == ASP_HOLD) || read_end;
    end
  end

  // read data kept until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_data_ff <= 18'h00000;
    end else if (read_end) begin
      rsp_data_ff <= sync3_ff;
    end
  end
endmodule
`default_nettype wire

// *** asp_host_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire asp_pkg::asp_addr_t mem_addr,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic lo_byte_strobe_n,
  input wire logic hi_byte_strobe_n,
  input wire logic shared_data_pins_oe
);
  wire logic wr;
  assign wr = !lo_byte_strobe_n || !hi_byte_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rd_no_wr: assert property (!out_en_n |-> !wr) else $error("rd");
  a_addr_held: assert property (wr || $past(wr) |-> $stable(mem_addr)) else $error("addr");
  a_wr_bus: assert property (wr |-> shared_data_pins_oe && !chip_sel_n) else $error("wr");
  a_cs_late: assert property ($fell(chip_sel_n) |-> $stable(mem_addr)) else $error("cs");
  a_pulse_width: assert property ($rose(wr) |-> wr[*3]) else $error("pulse");
  a_sel_past_wr: assert property ($fell(wr) |-> !chip_sel_n) else $error("sel");
endmodule
bind asp_host asp_chk i_asp_chk (.*);
`default_nettype wire

// *** asp_pkg.sv ***
package asp_pkg;
  typedef logic [15:0] asp_addr_t;
  typedef logic [17:0] asp_data_t;
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    asp_addr_t addr;
    asp_data_t wdata;
  } asp_req_s;
  typedef enum logic [2:0] {ASP_IDLE, ASP_SETUP, ASP_STROBE, ASP_HOLD, ASP_READ,
    ASP_OFF} asp_state_e;
endpackage

// *** asp_sram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_sram (
  input wire logic [15:0] a,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic lo_n,
  input wire logic hi_n,
  input wire logic d_oe,
  input wire logic [17:0] d,
  output wire logic [17:0] q
);
  logic [17:0] m [65536];
  wire logic drv;
  assign drv = !cs_n && !oe_n && lo_n && hi_n;
  always @(posedge lo_n) if (!cs_n) m[a][8:0] = d[8:0];
  always @(posedge hi_n) if (!cs_n) m[a][17:9] = d[17:9];
  assign #3 q = d_oe ? d : drv ? m[a] : ~m[a];
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import asp_pkg::*;
  logic clk = 0, rst_b = 0, req_valid = 0, req_ready, rsp_valid, cs_n, oe_n, lo_n, hi_n, d_oe;
  logic hold_a, hold_d;
  asp_req_s req = '0;
  asp_data_t rsp_data, d, q;
  asp_addr_t a;
  int failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  asp_host i_asp_host (.clk, .rst_b, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
    .mem_addr(a), .chip_sel_n(cs_n), .out_en_n(oe_n), .lo_byte_strobe_n(lo_n),
    .hi_byte_strobe_n(hi_n), .addr_hold_ctl(hold_a), .din_hold_ctl(hold_d), .shared_data_pins_in(q),
    .shared_data_pins_out(d), .shared_data_pins_oe(d_oe));
  asp_sram i_asp_sram (.a, .cs_n, .oe_n, .lo_n, .hi_n, .d_oe, .d, .q);
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check_val(input string what, input asp_data_t exp, input asp_data_t got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic x(input logic w, input logic [1:0] b, input asp_addr_t ad, input asp_data_t e);
    int n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 10);
    check_val("req_ready", 18'h1, {17'h0, req_ready});
    req = '{w, b, ad, e};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    if (!w || b != 2'h0) begin
      while (rsp_valid !== 1'b1 && n < 30) begin
        @(posedge clk);
        #1;
        n++;
      end
      check_val("rsp_valid", 18'h1, {17'h0, rsp_valid});
      if (!w) check_val("rdata", e, rsp_data);
    end
    if ((!w || b != 2'h0) && rsp_valid !== 1'b1) wrap_up;
  endtask
  task automatic t_bytes;
    x(1'b1, 2'h3, 16'h0005, 18'h3ffff);
    x(1'b1, 2'h1, 16'h0005, 18'h00000);
    x(1'b0, 2'h0, 16'h0005, 18'h3fe00);
    x(1'b1, 2'h2, 16'h0005, 18'h155ff);
    x(1'b0, 2'h0, 16'h0005, 18'h15400);
    x(1'b1, 2'h0, 16'h0005, 18'h3ffff);
    check_val("req_ready", 18'h1, {17'h0, req_ready});
    x(1'b1, 2'h3, 16'h0006, 18'h2a5a5);
    x(1'b0, 2'h0, 16'h0005, 18'h15400);
    x(1'b0, 2'h0, 16'h0006, 18'h2a5a5);
    $display("bytes end");
  endtask
  task automatic t_reset;
    check_val("addr_hold_ctl", 18'h1, {17'h0, hold_a});
    check_val("din_hold_ctl", 18'h1, {17'h0, hold_d});
    rst_b = 1'b0;
    @(posedge clk);
    #1;
    check_val("chip_sel_n", 18'h1, {17'h0, cs_n});
    rst_b = 1'b1;
    x(1'b0, 2'h0, 16'h0005, 18'h15400);
    $display("reset end");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1;
    t_bytes;
    t_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
